/* File: verilog/qlog_pkg.sv */
// Package with capability layouts, codes and APB register map of the queue log feature logic.
package qlog_pkg;
	localparam logic [7:0] ADDR_W = 8'h08;
	// APB register byte offsets.
	localparam logic [7:0] OFF_CAP = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_CMD = 8'h08;
	localparam logic [7:0] OFF_RESULT = 8'h0c;
	localparam logic [7:0] OFF_QLOG0 = 8'h10;
	localparam logic [7:0] OFF_QLOG1 = 8'h14;
	localparam logic [7:0] OFF_IDW = 8'h18;
	localparam logic [7:0] OFF_RA_LOG = 8'h1c;
	localparam logic [7:0] OFF_RA_WR = 8'h20;
	localparam logic [7:0] OFF_RD_REQ = 8'h24;
	localparam logic [7:0] OFF_RD_ERR = 8'h28;
	localparam logic [7:0] OFF_ERR_FIRST = 8'h2c;
	localparam logic [7:0] OFF_ERR_FINAL = 8'h30;
	localparam logic [7:0] OFF_LOGACC = 8'h34;
	// Capability register fields (reset values of the strap-like capability word).
	localparam logic [4:0] ABORT_CAP_RST = 5'h1f;
	localparam logic [2:0] DL_CAP_RST = 3'h7;
	localparam logic [3:0] SCT_AC_RST = 4'hf;
	localparam logic [3:0] VENDOR_RST = 4'h0;
	localparam int CAP_DL_LSB = 8;
	localparam int CAP_SCT_LSB = 16;
	localparam int CAP_VEND_LSB = 20;
	localparam int CAP_RA_BIT = 24;
	localparam int CAP_SCT_BIT = 25;
	// Queue management command fields.
	localparam logic [3:0] SUB_ABORT = 4'h0;
	localparam logic [3:0] SUB_DEADLINE = 4'h1;
	localparam logic [3:0] AT_ALL = 4'h0;
	localparam logic [3:0] AT_STREAM = 4'h1;
	localparam logic [3:0] AT_NONSTREAM = 4'h2;
	localparam logic [3:0] AT_SELECTED = 4'h3;
	localparam int CMD_WNC_BIT = 8;
	localparam int CMD_RNC_BIT = 9;
	localparam int CMD_AT_LSB = 4;
	// Result status.
	localparam logic [7:0] STS_OK = 8'h50;
	localparam logic [7:0] STS_ERR = 8'h51;
	localparam logic [7:0] ERR_ABRT = 8'h04;
	localparam logic [3:0] SENSE_ABORTED = 4'hb;
	localparam logic [15:0] ASC_MULTI_READ = 16'h1103;
	// Identify word and bit positions.
	localparam logic [7:0] IDW_RA = 8'd78;
	localparam int IDW_RA_BIT = 11;
	localparam logic [7:0] IDW_SCT = 8'd206;
	// Rebuild assist log layout.
	localparam logic [2:0] ELEM_LEN = 3'd1;
	localparam logic [7:0] ELEM_MASK_RST = 8'hff;
	localparam logic [7:0] LOG_RA_BYTE_LEN = 8'd7;
	localparam logic [7:0] LOG_PAGE_CMD = 8'he0;
	localparam logic [7:0] LOG_PAGE_DATA = 8'he1;
	localparam logic [7:0] LOG_DIR_LEN = 8'h01;
	localparam logic [31:0] BAD_ADDR_DATA = 32'hdead_0bad;
endpackage : qlog_pkg

/* File: verilog/qlog_decode.sv */
// Combinational decode of a queue management command against the capability flags.
module qlog_decode (
	input wire logic [3:0] subcmd_i,
	input wire logic [3:0] abort_type_i,
	input wire logic wnc_i,
	input wire logic rnc_i,
	input wire logic [4:0] abort_cap_i,
	input wire logic [2:0] dl_cap_i,
	output logic accept_o,
	output logic wnc_act_o,
	output logic rnc_act_o
);
	always_comb begin
		accept_o = 1'b0;
		wnc_act_o = 1'b0;
		rnc_act_o = 1'b0;
		if (subcmd_i == qlog_pkg::SUB_ABORT) begin
			if (abort_cap_i[0]) begin
				case (abort_type_i)
					qlog_pkg::AT_ALL: accept_o = abort_cap_i[1];
					qlog_pkg::AT_STREAM: accept_o = abort_cap_i[2];
					qlog_pkg::AT_NONSTREAM: accept_o = abort_cap_i[3];
					qlog_pkg::AT_SELECTED: accept_o = abort_cap_i[4];
					default: accept_o = 1'b0;
				endcase
			end
		end else if (subcmd_i == qlog_pkg::SUB_DEADLINE) begin
			accept_o = dl_cap_i[0];
			// An asserted bit whose support flag is clear makes the whole command unsupported.
			if (wnc_i && !dl_cap_i[1]) begin
				accept_o = 1'b0;
			end
			if (rnc_i && !dl_cap_i[2]) begin
				accept_o = 1'b0;
			end
			wnc_act_o = dl_cap_i[0] && dl_cap_i[1] && wnc_i;
			rnc_act_o = dl_cap_i[0] && dl_cap_i[2] && rnc_i;
		end
	end
endmodule : qlog_decode

/* File: verilog/qlog_feature.sv */
// Queue management capability, rebuild assist and command transport logic with an APB slave.
module qlog_feature (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic cmd_done_o,
	output logic cmd_err_o,
	output logic wnc_act_o,
	output logic rnc_act_o,
	output logic sct_cmd_o,
	output logic sct_data_o
);
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [4:0] abort_cap;
		logic [2:0] dl_cap;
		logic [3:0] sct_ac;
		logic [3:0] vendor;
		logic ra_sup;
		logic sct_sup;
		logic ra_enable;
		logic [7:0] elem_mask;
		logic [7:0] elem_dis;
		logic security_on;
		logic unlocked;
		logic smart_on;
		logic [7:0] status;
		logic [7:0] err;
		logic wnc_state;
		logic rnc_state;
		logic [3:0] sense_key;
		logic [15:0] asc;
		logic [15:0] first_addr;
		logic [15:0] final_addr;
		logic cmd_done;
		logic cmd_err;
		logic sct_cmd;
		logic sct_data;
	} state_t;

	state_t q, d;
	logic acc;
	logic wnc_act;
	logic rnc_act;
	logic [31:0] w;

	qlog_decode u_dec (
		.subcmd_i(pwdata_i[3:0]),
		.abort_type_i(pwdata_i[qlog_pkg::CMD_AT_LSB +: 4]),
		.wnc_i(pwdata_i[qlog_pkg::CMD_WNC_BIT]),
		.rnc_i(pwdata_i[qlog_pkg::CMD_RNC_BIT]),
		.abort_cap_i(q.abort_cap),
		.dl_cap_i(q.dl_cap),
		.accept_o(acc),
		.wnc_act_o(wnc_act),
		.rnc_act_o(rnc_act)
	);

	// Element index of a sector address: the low three address bits pick one of eight elements.
	function automatic logic elem_predicted(input logic [7:0] dis, input logic [7:0] mask, input logic [15:0] a);
		elem_predicted = dis[a[2:0]] & mask[a[2:0]];
	endfunction : elem_predicted

	assign w = pwdata_i;

	always_comb begin
		logic setup;
		logic wr;
		logic rd;
		logic pred;
		logic [15:0] a;
		logic [15:0] e;
		setup = psel_i && !penable_i;
		wr = 1'b0;
		rd = 1'b0;
		pred = 1'b0;
		a = 16'h0000;
		e = 16'h0000;
		d = q;
		d.cmd_done = 1'b0;
		d.sct_cmd = 1'b0;
		d.sct_data = 1'b0;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		// Answer one cycle after setup, so every access takes exactly two cycles.
		if (setup) begin
			d.pready = 1'b1;
			wr = pwrite_i;
			rd = !pwrite_i;
			d.prdata = 32'h0000_0000;
			case (paddr_i)
				qlog_pkg::OFF_CAP: begin
					if (wr) begin
						d.abort_cap = w[4:0];
						d.dl_cap = w[qlog_pkg::CAP_DL_LSB +: 3];
						d.sct_ac = w[qlog_pkg::CAP_SCT_LSB +: 4];
						d.vendor = w[qlog_pkg::CAP_VEND_LSB +: 4];
						d.ra_sup = w[qlog_pkg::CAP_RA_BIT];
						d.sct_sup = w[qlog_pkg::CAP_SCT_BIT];
					end
					d.prdata[4:0] = q.abort_cap;
					d.prdata[qlog_pkg::CAP_DL_LSB +: 3] = q.dl_cap;
					d.prdata[qlog_pkg::CAP_SCT_LSB +: 4] = q.sct_ac;
					d.prdata[qlog_pkg::CAP_VEND_LSB +: 4] = q.vendor;
					d.prdata[qlog_pkg::CAP_RA_BIT] = q.ra_sup;
					d.prdata[qlog_pkg::CAP_SCT_BIT] = q.sct_sup;
				end
				qlog_pkg::OFF_CTRL: begin
					if (wr) begin
						d.security_on = w[0];
						d.unlocked = w[1];
						d.smart_on = w[2];
					end
					d.prdata[2:0] = {q.smart_on, q.unlocked, q.security_on};
				end
				qlog_pkg::OFF_CMD: begin
					if (wr) begin
						d.cmd_done = 1'b1;
						if (acc) begin
							d.status = qlog_pkg::STS_OK;
							d.err = 8'h00;
							d.cmd_err = 1'b0;
							if (w[3:0] == qlog_pkg::SUB_DEADLINE) begin
								d.wnc_state = wnc_act;
								d.rnc_state = rnc_act;
							end
						end else begin
							d.status = qlog_pkg::STS_ERR;
							d.err = qlog_pkg::ERR_ABRT;
							d.cmd_err = 1'b1;
						end
					end
					d.prdata[1:0] = {q.rnc_state, q.wnc_state};
				end
				qlog_pkg::OFF_RESULT: d.prdata[15:0] = {q.err, q.status};
				qlog_pkg::OFF_QLOG0: d.prdata[4:0] = q.abort_cap;
				qlog_pkg::OFF_QLOG1: d.prdata[2:0] = q.dl_cap;
				qlog_pkg::OFF_IDW: begin
					if (w[7:0] == qlog_pkg::IDW_RA || !wr) begin
						d.prdata = 32'h0000_0000;
					end
				end
				qlog_pkg::OFF_RA_LOG: begin
					if (q.ra_sup) begin
						d.prdata[7:0] = {7'h00, q.ra_enable};
						d.prdata[10:8] = qlog_pkg::ELEM_LEN;
						d.prdata[23:16] = q.elem_mask;
						d.prdata[31:24] = q.elem_dis;
					end else begin
						d.pslverr = 1'b1;
					end
				end
				qlog_pkg::OFF_RA_WR: begin
					if (wr && q.ra_sup) begin
						d.ra_enable = w[0];
						// Length and mask from the host are dropped; only supported bits may disable.
						d.elem_dis = w[31:24] & q.elem_mask;
					end
				end
				qlog_pkg::OFF_RD_REQ: begin
					if (wr) begin
						d.cmd_done = 1'b1;
						a = w[15:0];
						pred = q.ra_enable && !w[16] && elem_predicted(q.elem_dis, q.elem_mask, a);
						if (pred) begin
							// Walk the contiguous run: higher neighbours in disabled elements are also predicted.
							e = a;
							for (int i = 1; i < 8; i++) begin
								if (e == a + 16'(i - 1) && elem_predicted(q.elem_dis, q.elem_mask, a + 16'(i))) begin
									e = a + 16'(i);
								end
							end
							d.sense_key = qlog_pkg::SENSE_ABORTED;
							d.asc = qlog_pkg::ASC_MULTI_READ;
							d.first_addr = a;
							d.final_addr = e;
							d.cmd_err = 1'b1;
							d.status = qlog_pkg::STS_ERR;
							d.err = qlog_pkg::ERR_ABRT;
						end else begin
							d.cmd_err = 1'b0;
							d.status = qlog_pkg::STS_OK;
							d.err = 8'h00;
						end
					end
				end
				qlog_pkg::OFF_RD_ERR: d.prdata[19:0] = {q.sense_key, q.asc};
				qlog_pkg::OFF_ERR_FIRST: d.prdata[15:0] = q.first_addr;
				qlog_pkg::OFF_ERR_FINAL: d.prdata[15:0] = q.final_addr;
				qlog_pkg::OFF_LOGACC: begin
					// Bits: 7:0 page, 8 write, 9 path (monitoring or extended), ignored alike.
					if (wr) begin
						d.cmd_done = 1'b1;
						if (w[7:0] == qlog_pkg::LOG_PAGE_CMD) begin
							if (q.security_on && !q.unlocked) begin
								d.cmd_err = 1'b1;
								d.status = qlog_pkg::STS_ERR;
								d.err = qlog_pkg::ERR_ABRT;
							end else begin
								d.cmd_err = 1'b0;
								d.status = qlog_pkg::STS_OK;
								d.err = 8'h00;
								d.sct_cmd = w[8];
							end
						end else if (w[7:0] == qlog_pkg::LOG_PAGE_DATA) begin
							d.sct_data = 1'b1;
							d.cmd_err = 1'b0;
						end else begin
							d.cmd_err = 1'b1;
						end
					end
					d.prdata[7:0] = qlog_pkg::LOG_DIR_LEN;
				end
				default: begin
					d.pslverr = 1'b1;
					d.prdata = qlog_pkg::BAD_ADDR_DATA;
				end
			endcase
			// Identify read: word number in bits 7:0 of the address register write is not needed;
			// word 78 and 206 are returned together in one read of the identify register.
			if (paddr_i == qlog_pkg::OFF_IDW && rd) begin
				d.prdata[qlog_pkg::IDW_RA_BIT] = q.ra_sup;
				d.prdata[16] = q.sct_sup;
				d.prdata[21:18] = q.sct_ac;
				d.prdata[31:28] = q.vendor;
			end
		end
		if (rst_i) begin
			d = '0;
			d.abort_cap = qlog_pkg::ABORT_CAP_RST;
			d.dl_cap = qlog_pkg::DL_CAP_RST;
			d.sct_ac = qlog_pkg::SCT_AC_RST;
			d.vendor = qlog_pkg::VENDOR_RST;
			d.ra_sup = 1'b1;
			d.sct_sup = 1'b1;
			d.elem_mask = qlog_pkg::ELEM_MASK_RST;
			d.status = qlog_pkg::STS_OK;
		end
	end

	always_ff @(posedge core_clk_i) begin
		q <= d;
	end

	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign cmd_done_o = q.cmd_done;
	assign cmd_err_o = q.cmd_err;
	assign wnc_act_o = q.wnc_state;
	assign rnc_act_o = q.rnc_state;
	assign sct_cmd_o = q.sct_cmd;
	assign sct_data_o = q.sct_data;
endmodule : qlog_feature

/* File: sim/qlog_feature_assertions.sv */
// Concurrent checks on the ports of the queue log feature logic.
module qlog_feature_assertions (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic cmd_done_o,
	input wire logic cmd_err_o,
	input wire logic wnc_act_o,
	input wire logic rnc_act_o,
	input wire logic sct_cmd_o,
	input wire logic sct_data_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_acc(logic [7:0] a, logic w);
		psel_i && !penable_i && pwrite_i == w && paddr_i == a;
	endsequence
	sequence s_log(logic [7:0] pg, logic w);
		s_acc(qlog_pkg::OFF_LOGACC, 1'b1) ##0 (pwdata_i[7:0] == pg && pwdata_i[8] == w);
	endsequence
	property p_sct_cmd;
		s_log(qlog_pkg::LOG_PAGE_CMD, 1'b1) |=> sct_cmd_o != cmd_err_o;
	endproperty
	a_sct_cmd: assert property (p_sct_cmd) else $error("transport command neither issued nor failed");
	property p_sct_data;
		s_log(qlog_pkg::LOG_PAGE_DATA, 1'b0) |=> sct_data_o && !cmd_err_o;
	endproperty
	a_sct_data: assert property (p_sct_data) else $error("data page read gave no data pulse");
	property p_data_cause;
		sct_data_o |-> $past(psel_i && !penable_i && paddr_i == qlog_pkg::OFF_LOGACC);
	endproperty
	a_data_cause: assert property (p_data_cause) else $error("data pulse without log access");
	property p_bypass;
		s_acc(qlog_pkg::OFF_RD_REQ, 1'b1) ##0 pwdata_i[16] |=> cmd_done_o && !cmd_err_o;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass read reported an error");
	property p_dir_len;
		s_acc(qlog_pkg::OFF_LOGACC, 1'b0) |=> prdata_o == 32'h00000001;
	endproperty
	a_dir_len: assert property (p_dir_len) else $error("directory length is not one");
	property p_qlog;
		s_acc(qlog_pkg::OFF_QLOG0, 1'b0) or s_acc(qlog_pkg::OFF_QLOG1, 1'b0) |=> prdata_o[31:5] == 27'h0;
	endproperty
	a_qlog: assert property (p_qlog) else $error("queue log reserved bits set");
	property p_idw;
		s_acc(qlog_pkg::OFF_IDW, 1'b0) |=> (prdata_o & 32'h0fc2f7ff) == 32'h0;
	endproperty
	a_idw: assert property (p_idw) else $error("identify reserved bits set");
	property p_ra_log;
		s_acc(qlog_pkg::OFF_RA_LOG, 1'b0) |=> pslverr_o ||
			(prdata_o[10:8] == qlog_pkg::ELEM_LEN && (prdata_o[31:24] & ~prdata_o[23:16]) == 8'h00);
	endproperty
	a_ra_log: assert property (p_ra_log) else $error("rebuild log length or mask wrong");
	property p_wnc;
		$rose(wnc_act_o) |-> $past(psel_i && !penable_i && pwrite_i && paddr_i == qlog_pkg::OFF_CMD && pwdata_i[8]);
	endproperty
	a_wnc: assert property (p_wnc) else $error("write-no-continue rose without request");
	property p_rnc;
		$rose(rnc_act_o) |-> $past(psel_i && !penable_i && paddr_i == qlog_pkg::OFF_CMD && pwdata_i[9]);
	endproperty
	a_rnc: assert property (p_rnc) else $error("read-no-continue rose without request");
endmodule : qlog_feature_assertions

bind qlog_feature qlog_feature_assertions u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .cmd_done_o(cmd_done_o), .cmd_err_o(cmd_err_o),
	.wnc_act_o(wnc_act_o), .rnc_act_o(rnc_act_o), .sct_cmd_o(sct_cmd_o), .sct_data_o(sct_data_o));

/* File: sim/apb_host.sv */
// Behavioural APB host standing in for the array controller.
module apb_host (
	input wire logic core_clk_i,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge core_clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge core_clk_i);
		penable_o <= 1'b1;
		do @(posedge core_clk_i); while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released address and data lines are inverted so that a stale value never passes for a fresh one.
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask : xfer
endmodule : apb_host

/* File: sim/tb_drive_queue_log_feature_logic.sv */
// Self-checking testbench of the queue log feature logic.
module tb_drive_queue_log_feature_logic;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CAPR = 32'h030f071f;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, done, err, wnc, rnc, scmd, sdat;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int ncmd = 0;
	int ndat = 0;
	qlog_feature u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .cmd_done_o(done), .cmd_err_o(err), .wnc_act_o(wnc), .rnc_act_o(rnc),
		.sct_cmd_o(scmd), .sct_data_o(sdat));
	apb_host u_host (.core_clk_i(core_clk_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
	initial begin
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (scmd === 1'b1) ncmd <= ncmd + 1;
		if (sdat === 1'b1) ndat <= ndat + 1;
		if (cyc == 5000) end_sim(1'b1);
	end
	task automatic end_sim(input bit hang);
		if (hang) errors++;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		u_host.xfer(1'b1, a, d, r, e);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		u_host.xfer(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(32'(e), 32'(xe));
	endtask : rd
	task automatic t_reset();
		rd(qlog_pkg::OFF_CAP, CAPR, 1'b0);
		rd(qlog_pkg::OFF_QLOG0, 32'h1f, 1'b0);
		rd(qlog_pkg::OFF_QLOG1, 32'h7, 1'b0);
		rd(qlog_pkg::OFF_IDW, 32'h003d0800, 1'b0);
		rd(qlog_pkg::OFF_RA_LOG, 32'h00ff0100, 1'b0);
		rd(8'h40, qlog_pkg::BAD_ADDR_DATA, 1'b1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_abort();
		logic [31:0] c;
		for (int t = 0; t < 4; t++) begin
			c = CAPR & ~(32'h2 << t);
			wr(qlog_pkg::OFF_CAP, c);
			rd(qlog_pkg::OFF_QLOG0, c & 32'h1f, 1'b0);
			wr(qlog_pkg::OFF_CMD, {24'h0, 4'(t), qlog_pkg::SUB_ABORT});
			rd(qlog_pkg::OFF_RESULT, 32'h451, 1'b0);
			wr(qlog_pkg::OFF_CMD, {24'h0, 4'((t + 1) % 4), qlog_pkg::SUB_ABORT});
			rd(qlog_pkg::OFF_RESULT, 32'h50, 1'b0);
		end
		wr(qlog_pkg::OFF_CAP, CAPR & ~32'h1);
		wr(qlog_pkg::OFF_CMD, {24'h0, qlog_pkg::AT_ALL, qlog_pkg::SUB_ABORT});
		chk(32'(err), 32'h1);
		$display("test abort done");
	endtask : t_abort
	task automatic t_deadline();
		wr(qlog_pkg::OFF_CAP, CAPR & ~32'h400);
		rd(qlog_pkg::OFF_QLOG1, 32'h3, 1'b0);
		wr(qlog_pkg::OFF_CMD, 32'h101);
		chk(32'({err, rnc, wnc}), 32'h1);
		wr(qlog_pkg::OFF_CMD, 32'h201);
		chk(32'({err, rnc, wnc}), 32'h5);
		wr(qlog_pkg::OFF_CAP, CAPR & ~32'h200);
		wr(qlog_pkg::OFF_CMD, 32'h201);
		chk(32'({err, rnc, wnc}), 32'h2);
		rd(qlog_pkg::OFF_CMD, 32'h2, 1'b0);
		wr(qlog_pkg::OFF_CAP, CAPR & ~32'h100);
		wr(qlog_pkg::OFF_CMD, 32'h1);
		chk(32'({err, rnc, wnc}), 32'h6);
		$display("test deadline done");
	endtask : t_deadline
	task automatic t_rebuild();
		logic [31:0] r;
		logic e;
		wr(qlog_pkg::OFF_CAP, CAPR);
		wr(qlog_pkg::OFF_RA_WR, 32'h0c000001);
		rd(qlog_pkg::OFF_RA_LOG, 32'h0cff0101, 1'b0);
		wr(qlog_pkg::OFF_RD_REQ, 32'h12);
		rd(qlog_pkg::OFF_RD_ERR, 32'h000b1103, 1'b0);
		rd(qlog_pkg::OFF_ERR_FIRST, 32'h12, 1'b0);
		rd(qlog_pkg::OFF_ERR_FINAL, 32'h13, 1'b0);
		wr(qlog_pkg::OFF_RD_REQ, 32'h10012);
		chk(32'(err), 32'h0);
		wr(qlog_pkg::OFF_RD_REQ, 32'h11);
		chk(32'(err), 32'h0);
		wr(qlog_pkg::OFF_CAP, CAPR & ~32'h01000000);
		rd(qlog_pkg::OFF_IDW, 32'h003d0000, 1'b0);
		u_host.xfer(1'b0, qlog_pkg::OFF_RA_LOG, 32'h0, r, e);
		chk(32'(e), 32'h1);
		$display("test rebuild done");
	endtask : t_rebuild
	task automatic t_log();
		wr(qlog_pkg::OFF_CTRL, 32'h0);
		for (int p = 0; p < 2; p++) begin
			wr(qlog_pkg::OFF_LOGACC, {22'h0, 1'(p), 1'b1, qlog_pkg::LOG_PAGE_CMD});
			wr(qlog_pkg::OFF_LOGACC, {22'h0, 1'(p), 1'b0, qlog_pkg::LOG_PAGE_DATA});
			wr(qlog_pkg::OFF_LOGACC, {22'h0, 1'(p), 1'b1, qlog_pkg::LOG_PAGE_DATA});
		end
		chk(ncmd, 32'h2);
		chk(ndat, 32'h4);
		rd(qlog_pkg::OFF_LOGACC, 32'h1, 1'b0);
		wr(qlog_pkg::OFF_CTRL, 32'h1);
		wr(qlog_pkg::OFF_LOGACC, 32'h1e0);
		chk(32'(err), 32'h1);
		chk(ncmd, 32'h2);
		wr(qlog_pkg::OFF_CTRL, 32'h3);
		wr(qlog_pkg::OFF_LOGACC, 32'h1e0);
		chk(ncmd, 32'h3);
		$display("test log pages done");
	endtask : t_log
	initial begin
		repeat (12) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_abort();
		t_deadline();
		t_rebuild();
		t_log();
		end_sim(1'b0);
	end
endmodule : tb_drive_queue_log_feature_logic
